/* File: shared/adc_seq_pkg.sv */
// Register map, field positions, reset values and timing for the
// conversion sequencer. Assumes a 250 MHz system clock.
package adc_seq_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] PIN_ENABLE_OFF = 8'h00;
    localparam logic [7:0] CONTROL_OFF = 8'h04;
    localparam logic [7:0] RESULT_BYTE_OFF = 8'h08;
    localparam logic [7:0] RESULT_HIGH_OFF = 8'h0c;
    localparam logic [7:0] RESULT_LOW_OFF = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'h14;
    localparam logic [7:0] IRQ_CLEAR_OFF = 8'h18;
    localparam logic [7:0] IRQ_ENABLE_OFF = 8'h1c;

    // ----------------------------------------
    // Control and interrupt field positions
    // ----------------------------------------
    localparam int REF_SEL_BIT = 7;
    localparam int RATE_HI_BIT = 6;
    localparam int RATE_LO_BIT = 5;
    localparam int RUN_BIT = 4;
    localparam int POWER_BIT = 3;
    localparam int CHAN_HI_BIT = 1;
    localparam int CHAN_LO_BIT = 0;
    localparam int DONE_BIT = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] PIN_ENABLE_RESET = 4'h0;
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [1:0] CHAN_RESET = 2'h0;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [11:0] IRQ_VECTOR = 12'h00c;

    // ----------------------------------------
    // Clock rate codes
    // ----------------------------------------
    localparam logic [1:0] RATE_DIV16 = 2'h0;
    localparam logic [1:0] RATE_DIV4 = 2'h1;
    localparam logic [1:0] RATE_DIV64 = 2'h2;
    localparam logic [1:0] RATE_RC = 2'h3;
    localparam int DIV16_CYCLES = 16;
    localparam int DIV4_CYCLES = 4;
    localparam int DIV64_CYCLES = 64;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_MHZ = 250;
    localparam int RC_BIT_TIME_NS = 71000;
    localparam int RC_BIT_CYCLES = RC_BIT_TIME_NS * CLOCK_MHZ / 1000;
    localparam int BITS_PER_CONVERSION = 15;

    // Register decode used by the write paths; the read mux decodes the address itself
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

endpackage : adc_seq_pkg

/* File: sim/tb_adc_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer over its Avalon-MM slave.
// Assumes a single 250 MHz clock and a shortened RC bit period.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
    // Short RC period keeps the run small
    localparam int RC_CYCLES = 20;
    logic clock, rstn;
    logic [7:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [11:0] sar_result, vector_addr;
    logic core_sleep, global_irq_enable, irq, wake_core, vector_fetch;
    logic [3:0] pin_digital;
    logic converter_enable, reference_source_select;
    int num_errors, total_checks, cyc, wake_count, vector_count, t0, el, p;

    adc_conversion_sequencer #(.RC_BIT_CYCLES(RC_CYCLES)) i_dut (
        .clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sar_result(sar_result), .core_sleep(core_sleep),
        .global_irq_enable(global_irq_enable), .irq(irq), .wake_core(wake_core),
        .vector_fetch(vector_fetch), .vector_addr(vector_addr), .pin_digital(pin_digital),
        .converter_enable(converter_enable), .reference_source_select(reference_source_select)
    );

    // ----------------------------------------
    // Clock and event counters
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wake_core === 1'b1) wake_count <= wake_count + 1;
        if (vector_fetch === 1'b1) vector_count <= vector_count + 1;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic hang(input string what);
        num_errors++;
        $display("CHECK FAILED %0t timeout %s", $time, what);
        complete_run();
    endtask : hang

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= addr;
        avs_writedata <= data;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) hang("bus");
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] q;
        bus(1'b1, addr, data, q);
    endtask : wr

    task automatic rdreg(input logic [7:0] addr);
        bus(1'b0, addr, 32'h0, rd);
    endtask : rdreg

    function automatic logic [31:0] ctl(input logic [1:0] rate, input logic run, input logic [1:0] chan);
        ctl = 32'h0;
        ctl[adc_seq_pkg::RATE_HI_BIT:adc_seq_pkg::RATE_LO_BIT] = rate;
        ctl[adc_seq_pkg::RUN_BIT] = run;
        ctl[adc_seq_pkg::POWER_BIT] = 1'b1;
        ctl[adc_seq_pkg::CHAN_HI_BIT:adc_seq_pkg::CHAN_LO_BIT] = chan;
    endfunction : ctl

    function automatic int period(input logic [1:0] rate);
        case (rate)
            adc_seq_pkg::RATE_DIV16: period = adc_seq_pkg::DIV16_CYCLES;
            adc_seq_pkg::RATE_DIV4: period = adc_seq_pkg::DIV4_CYCLES;
            adc_seq_pkg::RATE_DIV64: period = adc_seq_pkg::DIV64_CYCLES;
            default: period = RC_CYCLES;
        endcase
    endfunction : period

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clock);
            n++;
            if (n > 5000) hang("irq");
        end
    endtask : wait_irq

    task automatic clear_done(input logic [1:0] rate);
        wr(adc_seq_pkg::IRQ_CLEAR_OFF, 32'h1);
        rdreg(adc_seq_pkg::IRQ_STATUS_OFF);
        chk(rd, 32'h0, "done cleared");
        chk(32'(irq), 32'h0, "irq low");
        repeat (2 * period(rate)) @(posedge clock);
    endtask : clear_done

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        sar_result = 12'h000;
        core_sleep = 1'b0;
        global_irq_enable = 1'b0;
        num_errors = 0;
        total_checks = 0;
        cyc = 0;
        wake_count = 0;
        vector_count = 0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        chk(32'(avs_waitrequest), 32'h1, "idle waitrequest");
        chk(32'(pin_digital), 32'hf, "reset pins digital");
        chk(32'(vector_addr), 32'(adc_seq_pkg::IRQ_VECTOR), "vector address");
        rdreg(8'h20);
        chk(rd, 32'h0, "unmapped read");
        wr(adc_seq_pkg::PIN_ENABLE_OFF, 32'h5);
        rdreg(adc_seq_pkg::PIN_ENABLE_OFF);
        chk(rd, 32'h5, "pin enables");
        chk(32'(pin_digital), 32'ha, "digital pins");
        wr(adc_seq_pkg::IRQ_ENABLE_OFF, 32'h1);
        wr(adc_seq_pkg::CONTROL_OFF, ctl(2'h0, 1'b0, 2'h0));
        repeat (500) @(posedge clock);
        for (int r = 0; r < 4; r++) begin
            p = period(2'(r));
            sar_result <= 12'ha5c + 12'(r * 291);
            wr(adc_seq_pkg::CONTROL_OFF, ctl(2'(r), 1'b1, 2'h0));
            t0 = cyc;
            wr(adc_seq_pkg::CONTROL_OFF, ctl(2'(r), 1'b0, 2'h0));
            rdreg(adc_seq_pkg::CONTROL_OFF);
            chk(32'(rd[adc_seq_pkg::RUN_BIT]), 32'h1, "run kept");
            wait_irq();
            el = cyc - t0;
            // fifteen periods, run edge to irq seen
            chk(32'(el), 32'(15 * p + 3), "conversion time");
            rdreg(adc_seq_pkg::RESULT_BYTE_OFF);
            chk(rd, 32'(sar_result[11:4]), "result byte");
            rdreg(adc_seq_pkg::RESULT_HIGH_OFF);
            chk(rd, 32'(sar_result[11:8]), "result high");
            rdreg(adc_seq_pkg::RESULT_LOW_OFF);
            chk(rd, 32'(sar_result[7:0]), "result low");
            rdreg(adc_seq_pkg::CONTROL_OFF);
            chk(32'(rd[adc_seq_pkg::RUN_BIT]), 32'h0, "run cleared");
            rdreg(adc_seq_pkg::IRQ_STATUS_OFF);
            rdreg(adc_seq_pkg::IRQ_STATUS_OFF);
            chk(rd, 32'h1, "done kept after read");
            if (r == 3) begin
                wr(adc_seq_pkg::CONTROL_OFF, ctl(2'(r), 1'b0, 2'h2));
                rdreg(adc_seq_pkg::CONTROL_OFF);
                chk(32'(rd[1:0]), 32'h0, "channel locked");
            end
            clear_done(2'(r));
        end
        wr(adc_seq_pkg::CONTROL_OFF, ctl(2'h3, 1'b0, 2'h2) | (32'h1 << adc_seq_pkg::REF_SEL_BIT));
        rdreg(adc_seq_pkg::CONTROL_OFF);
        chk(32'(rd[1:0]), 32'h2, "channel taken");
        chk(32'(rd[adc_seq_pkg::REF_SEL_BIT]), 32'h1, "ref select bit");
        chk(32'(reference_source_select), 32'h1, "ref select pin");
        rdreg(adc_seq_pkg::RESULT_LOW_OFF);
        chk(rd, 32'h0, "results cleared");
        // Sleep with global enable, then without
        for (int g = 1; g >= 0; g--) begin
            core_sleep <= 1'b1;
            global_irq_enable <= 1'(g);
            wr(adc_seq_pkg::CONTROL_OFF, ctl(2'h1, 1'b1, 2'h2));
            wait_irq();
            chk(32'(wake_count), 32'(2 - g), "wake pulses");
            chk(32'(vector_count), 32'h1, "vector pulses");
            core_sleep <= 1'b0;
            clear_done(2'h1);
        end
        // No irq enable: completion in sleep shuts the converter
        wr(adc_seq_pkg::IRQ_ENABLE_OFF, 32'h0);
        core_sleep <= 1'b1;
        wr(adc_seq_pkg::CONTROL_OFF, ctl(2'h1, 1'b1, 2'h2));
        rd = 32'h0;
        for (int n = 0; n < 100 && rd !== 32'h1; n++) rdreg(adc_seq_pkg::IRQ_STATUS_OFF);
        if (rd !== 32'h1) hang("done");
        chk(32'(wake_count), 32'h2, "no wake");
        chk(32'(converter_enable), 32'h0, "converter off");
        rdreg(adc_seq_pkg::CONTROL_OFF);
        chk(32'(rd[adc_seq_pkg::POWER_BIT]), 32'h0, "power bit off");
        chk(32'(irq), 32'h0, "masked irq");
        chk(32'(reference_source_select), 32'h0, "ref select cleared");
        complete_run();
    end
endmodule : tb_adc_conversion_sequencer
`default_nettype wire

/* File: src/adc_bit_pacer.sv */
// Bit period pacer: one tick per result bit at the selected rate.
// Assumes its reset is already synchronised by the caller.
`timescale 1ns/1ps
`default_nettype none
module adc_bit_pacer #(
    parameter int RC_BIT_CYCLES = adc_seq_pkg::RC_BIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic active,
    input wire logic [1:0] rate_sel,
    // Pacing
    output logic bit_tick
);

    logic [14:0] count;
    logic [14:0] limit;

    // ----------------------------------------
    // Rate decode
    // ----------------------------------------
    // divider or RC period
    always_comb begin
        case (rate_sel)
            adc_seq_pkg::RATE_DIV16: limit = 15'(adc_seq_pkg::DIV16_CYCLES - 1);
            adc_seq_pkg::RATE_DIV4: limit = 15'(adc_seq_pkg::DIV4_CYCLES - 1);
            adc_seq_pkg::RATE_DIV64: limit = 15'(adc_seq_pkg::DIV64_CYCLES - 1);
            default: limit = 15'(RC_BIT_CYCLES - 1);
        endcase
    end

    assign bit_tick = active && (count >= limit);

    // Counter restarts each conversion so every bit is a full period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 15'h0000;
        end else if (!active || bit_tick) begin
            count <= 15'h0000;
        end else begin
            count <= count + 15'h0001;
        end
    end

endmodule : adc_bit_pacer
`default_nettype wire

/* File: src/adc_conversion_sequencer.sv */
// Conversion sequencer with Avalon-MM register slave and interrupt.
// Assumes synchronous inputs, a 250 MHz clock and a SAR result bus.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer #(
    parameter int RC_BIT_CYCLES = adc_seq_pkg::RC_BIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Converter and core
    input wire logic [11:0] sar_result,
    input wire logic core_sleep,
    input wire logic global_irq_enable,
    // Outputs
    output logic irq,
    output logic wake_core,
    output logic vector_fetch,
    output logic [11:0] vector_addr,
    output logic [3:0] pin_digital,
    output logic converter_enable,
    output logic reference_source_select
);

    typedef enum logic {IDLE, CONVERT} state_t;

    logic rst_meta;
    logic rst_n;
    state_t state;
    logic [3:0] bit_count;
    logic bit_tick;
    logic finish;
    logic access;
    logic wr_ctrl;
    logic chan_write_ok;
    logic [31:0] next_readdata;
    logic [3:0] analog_pin_enables;
    logic [1:0] clock_rate_select;
    logic conversion_run_bit;
    logic converter_power_on;
    logic [1:0] channel_select;
    logic [11:0] result;
    logic conversion_done_flag;
    logic conversion_irq_enable;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // Fixed one wait cycle keeps the read mux off the request path
    assign access = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_ctrl = access && avs_write
        && adc_seq_pkg::reg_hit(avs_address, adc_seq_pkg::CONTROL_OFF);
    assign chan_write_ok = wr_ctrl && !conversion_done_flag && !conversion_run_bit;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (access) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            adc_seq_pkg::PIN_ENABLE_OFF: next_readdata[3:0] = analog_pin_enables;
            adc_seq_pkg::CONTROL_OFF: begin
                next_readdata[adc_seq_pkg::REF_SEL_BIT] = reference_source_select;
                next_readdata[adc_seq_pkg::RATE_HI_BIT] = clock_rate_select[1];
                next_readdata[adc_seq_pkg::RATE_LO_BIT] = clock_rate_select[0];
                next_readdata[adc_seq_pkg::RUN_BIT] = conversion_run_bit;
                next_readdata[adc_seq_pkg::POWER_BIT] = converter_power_on;
                next_readdata[adc_seq_pkg::CHAN_HI_BIT] = channel_select[1];
                next_readdata[adc_seq_pkg::CHAN_LO_BIT] = channel_select[0];
            end
            adc_seq_pkg::RESULT_BYTE_OFF: next_readdata[7:0] = result[11:4];
            adc_seq_pkg::RESULT_HIGH_OFF: next_readdata[3:0] = result[11:8];
            adc_seq_pkg::RESULT_LOW_OFF: next_readdata[7:0] = result[7:0];
            // status read has no side effect
            adc_seq_pkg::IRQ_STATUS_OFF: next_readdata[adc_seq_pkg::DONE_BIT] = conversion_done_flag;
            adc_seq_pkg::IRQ_ENABLE_OFF: next_readdata[adc_seq_pkg::DONE_BIT] = conversion_irq_enable;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // not gated by core_sleep
    adc_bit_pacer #(
        .RC_BIT_CYCLES(RC_BIT_CYCLES)
    ) pacer (
        .clock(clock),
        .rst_n(rst_n),
        .active(state == CONVERT),
        .rate_sel(clock_rate_select),
        .bit_tick(bit_tick)
    );

    assign finish = (state == CONVERT) && bit_tick
        && (bit_count == 4'(adc_seq_pkg::BITS_PER_CONVERSION - 1));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
            bit_count <= 4'h0;
        end else begin
            case (state)
                IDLE: begin
                    bit_count <= 4'h0;
                    if (conversion_run_bit && converter_power_on) begin
                        state <= CONVERT;
                    end
                end
                CONVERT: begin
                    if (finish) begin
                        state <= IDLE;
                    end else if (bit_tick) begin
                        bit_count <= bit_count + 4'h1;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reference_source_select <= 1'b0;
            clock_rate_select <= adc_seq_pkg::RATE_RESET;
            channel_select <= adc_seq_pkg::CHAN_RESET;
        end else if (wr_ctrl) begin
            reference_source_select <= avs_writedata[adc_seq_pkg::REF_SEL_BIT];
            clock_rate_select <= avs_writedata[adc_seq_pkg::RATE_HI_BIT:adc_seq_pkg::RATE_LO_BIT];
            if (chan_write_ok) begin
                channel_select <= avs_writedata[adc_seq_pkg::CHAN_HI_BIT:adc_seq_pkg::CHAN_LO_BIT];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conversion_run_bit <= 1'b0;
        end else begin
            if (finish) begin
                conversion_run_bit <= 1'b0;
            end
            if (wr_ctrl && avs_writedata[adc_seq_pkg::RUN_BIT]) begin
                conversion_run_bit <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            converter_power_on <= 1'b0;
        end else if (wr_ctrl) begin
            converter_power_on <= avs_writedata[adc_seq_pkg::POWER_BIT];
        end else if (finish && core_sleep && !conversion_irq_enable) begin
            converter_power_on <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            analog_pin_enables <= adc_seq_pkg::PIN_ENABLE_RESET;
        end else if (access && avs_write
            && adc_seq_pkg::reg_hit(avs_address, adc_seq_pkg::PIN_ENABLE_OFF)) begin
            analog_pin_enables <= avs_writedata[3:0];
        end
    end

    // ----------------------------------------
    // Results
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result <= adc_seq_pkg::RESULT_RESET;
        end else if (finish) begin
            result <= sar_result;
        end else if (chan_write_ok
            && avs_writedata[adc_seq_pkg::CHAN_HI_BIT:adc_seq_pkg::CHAN_LO_BIT] != channel_select) begin
            result <= adc_seq_pkg::RESULT_RESET;
        end
    end

    // ----------------------------------------
    // Interrupt status and enable
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conversion_done_flag <= 1'b0;
        end else begin
            if (access && avs_write && avs_writedata[adc_seq_pkg::DONE_BIT]
                && adc_seq_pkg::reg_hit(avs_address, adc_seq_pkg::IRQ_CLEAR_OFF)) begin
                conversion_done_flag <= 1'b0;
            end
            if (finish) begin
                conversion_done_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conversion_irq_enable <= 1'b0;
        end else if (access && avs_write
            && adc_seq_pkg::reg_hit(avs_address, adc_seq_pkg::IRQ_ENABLE_OFF)) begin
            conversion_irq_enable <= avs_writedata[adc_seq_pkg::DONE_BIT];
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            wake_core <= 1'b0;
            vector_fetch <= 1'b0;
            vector_addr <= adc_seq_pkg::IRQ_VECTOR;
            pin_digital <= ~adc_seq_pkg::PIN_ENABLE_RESET;
            converter_enable <= 1'b0;
        end else begin
            irq <= conversion_done_flag && conversion_irq_enable;
            wake_core <= finish && core_sleep && conversion_irq_enable;
            vector_fetch <= finish && conversion_irq_enable && global_irq_enable;
            vector_addr <= adc_seq_pkg::IRQ_VECTOR;
            pin_digital <= ~analog_pin_enables;
            converter_enable <= converter_power_on;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    int conv_cycles;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conv_cycles <= 0;
        end else if (state == CONVERT) begin
            conv_cycles <= conv_cycles + 1;
        end else begin
            conv_cycles <= 0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    done_on_finish_a: assert property (finish |=> conversion_done_flag && !conversion_run_bit)
        else $error("done not set or run not cleared at finish");
    result_load_a: assert property (finish |=> result == $past(sar_result))
        else $error("result not loaded with run clear");
    div4_span_a: assert property (finish && clock_rate_select == adc_seq_pkg::RATE_DIV4
        |-> conv_cycles == 59)
        else $error("divide by 4 conversion length wrong");
    div64_span_a: assert property (finish && clock_rate_select == adc_seq_pkg::RATE_DIV64
        |-> conv_cycles == 959)
        else $error("divide by 64 conversion length wrong");
    run_sticky_a: assert property (conversion_run_bit && !finish |=> conversion_run_bit)
        else $error("run bit dropped without completion");
    chan_hold_a: assert property (conversion_done_flag || conversion_run_bit |=> $stable(channel_select))
        else $error("channel changed while busy");
    sleep_off_a: assert property (finish && core_sleep && !conversion_irq_enable && !wr_ctrl
        |=> !converter_power_on && !wake_core)
        else $error("converter not shut off in sleep");
    wake_vec_a: assert property (finish && core_sleep && conversion_irq_enable && global_irq_enable
        |=> wake_core && vector_fetch && vector_addr == 12'h00c)
        else $error("no wake with vector");
    wake_novec_a: assert property (finish && core_sleep && conversion_irq_enable && !global_irq_enable
        |=> wake_core && !vector_fetch)
        else $error("wake without vector wrong");
    pin_mode_a: assert property (##1 pin_digital == ~$past(analog_pin_enables))
        else $error("digital pin map wrong");
    sleep_runs_a: assert property (state == CONVERT && core_sleep && !finish |=> state == CONVERT)
        else $error("conversion stopped in sleep");

    conv_done_c: cover property (finish ##1 irq);
    sleep_wake_c: cover property (finish && core_sleep ##1 wake_core);
    chan_clear_c: cover property (chan_write_ok && result != 12'h000 ##1 result == 12'h000);

endmodule : adc_conversion_sequencer
`default_nettype wire
